//--- hw/aclink_controller.sv
// Purpose: AC-link controller, frames slots to and from a codec
// Assumes: mclk well above the codec bit clock; link pins async
// Notes:   bit clock is sampled, not used as a clock
// Summary of operation
// - Exchange all audio, modem, handset, command and status data over the link.
// - Support 10, 16, 18 and 20 bit samples inside 20-bit slots.
// - Variable rate: data slots carry data only when a sample waits.
// - Drive the frame sync output marking each 48 kHz frame.
// - Receive data on serial_in_line, transmit on serial_out_line.
// - Bus side on master clock, link side timed by codec bit clock.
// - Resynchronise every signal crossing between the two clock domains.
// - Operate only while the power manager enables the peripheral clock.
// - Each interrupt source enabled or disabled by separate set and clear inputs.
// - Interrupt line high when any source is pending and unmasked.
// - Mask and global status readable; their AND names the source.
// - Per-channel status shows the specific channel event.
// - Link is bidirectional, fixed frame rate, tag both ways every frame.
// - Frame is tag plus twelve 20-bit slots each way.
// - Outgoing slots: tag, command address, command data, then data slots.
// - Incoming slots: tag, status address, status data, then data slots.
// - Stream port moves samples without processor work each frame.
// - Tag is 16 bits: frame valid, twelve slot valid bits, codec id.
// - Command address: bit 19 read, bits 18:12 register index.
// - Command data in bits 19:4; all zero for a read.
`include "aclink_cfg.svh"
module aclink_controller (
    input  wire logic              mclk,               // Master clock
    input  wire logic              rst_b,              // Async reset, active low
    input  wire logic              ce,                 // Peripheral clock enable
    input  wire logic              link_on,            // Run frames
    input  wire logic              codec_bit_clock,    // Codec bit clock pin
    input  wire logic              serial_in_line,     // Data from codec
    output logic                   serial_out_line,    // Data to codec
    output logic                   frame_sync_line,    // Frame sync
    input  aclink_pkg::res_e       res_sel,            // Sample resolution
    input  wire logic              tx_wr_valid,        // Sample write strobe
    input  wire logic [3:0]        tx_wr_slot,         // Sample slot 3..12
    input  wire logic [19:0]       tx_wr_data,         // Sample, left-justified
    output logic                   tx_req,             // Frame start pulse
    input  wire logic              cmd_valid,          // Command request
    input  wire logic              cmd_read,           // 1 read, 0 write
    input  wire logic [6:0]        cmd_index,          // Codec register index
    input  wire logic [15:0]       cmd_data,           // Write data
    output logic                   cmd_ready,          // Ready to accept a command
    output logic                   rx_valid,           // Received sample pulse
    output logic [3:0]             rx_slot,            // Its slot
    output logic [19:0]            rx_data,            // Its data, masked
    output logic                   sts_valid,          // Status word pulse
    output logic [6:0]             sts_index,          // Status register index
    output logic [15:0]            sts_data,           // Status register data
    input  wire logic [1:0]        irq_en_set,         // Enable source pulses
    input  wire logic [1:0]        irq_dis,            // Disable source pulses
    input  wire logic [3:0]        cs_clear,           // Clear channel events
    output logic [1:0]             irq_mask_reg,       // Enabled sources
    output logic [1:0]             status_reg,         // Global status
    output logic [3:0]             channel_status_reg, // Channel events
    output logic                   irq                 // Interrupt line
);
    import aclink_pkg::*;

    logic        bclk_s1_ff, bclk_s2_ff, bclk_d3_ff;
    logic        sin_s1_ff, sin_s2_ff;
    link_e       state_ff, nxt_state;
    logic [3:0]  slot_ff;
    logic [4:0]  sbit_ff;
    logic [19:0] tx_sh_ff, rx_sh_ff;
    logic [12:0] valid_ff;
    logic [12:3] pend_ff;
    logic        cmd_pend_ff, cmd_rd_ff, live_rd_ff;
    logic [6:0]  cmd_idx_ff, live_idx_ff;
    logic [15:0] cmd_dat_ff, live_dat_ff, rx_tag_ff;
    logic [19:0] mem_rd_data;

    // Two flops on each pin; the third only for edge finding
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bclk_s1_ff <= 1'b0;
            bclk_s2_ff <= 1'b0;
            bclk_d3_ff <= 1'b0;
            sin_s1_ff  <= 1'b0;
            sin_s2_ff  <= 1'b0;
        end else if (ce) begin
            bclk_s1_ff <= codec_bit_clock;
            bclk_s2_ff <= bclk_s1_ff;
            bclk_d3_ff <= bclk_s2_ff;
            sin_s1_ff  <= serial_in_line;
            sin_s2_ff  <= sin_s1_ff;
        end
    end

    // Link-side timing from bit clock edges seen in mclk
    wire running   = (state_ff == LINK_RUN);
    wire bclk_rise = bclk_s2_ff & ~bclk_d3_ff;
    wire bclk_fall = ~bclk_s2_ff & bclk_d3_ff;
    wire tag_now   = (slot_ff == `ACL_TAG_SLOT);
    wire last_bit  = tag_now ? (sbit_ff == `ACL_TAG_LAST) : (sbit_ff == `ACL_DATA_LAST);
    wire [3:0] ns  = (slot_ff == `ACL_LAST_SLOT) ? `ACL_TAG_SLOT : slot_ff + 4'h1;
    wire adv       = running & bclk_rise;
    wire fr_start  = adv & last_bit & (slot_ff == `ACL_LAST_SLOT);
    wire stop      = fr_start & ~link_on;
    wire go        = fr_start & link_on;
    wire adv_cnt   = adv & ~stop;

    // Link start and stop only at frame boundaries
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LINK_IDLE: nxt_state = link_on ? LINK_RUN : LINK_IDLE;
            LINK_RUN:  nxt_state = stop ? LINK_IDLE : LINK_RUN;
            default:   nxt_state = LINK_IDLE;
        endcase
    end

    // Tag slot 16 bits, other slots 20 bits, 12 slots after the tag (10 of them data)
    wire [4:0] nxt_sbit = adv_cnt ? (last_bit ? 5'h00 : sbit_ff + 5'h01) : sbit_ff;
    wire [3:0] nxt_slot = (adv_cnt & last_bit) ? ns : slot_ff;

    // Low bits beyond the chosen resolution are forced to zero
    wire [19:0] res_mask = (res_sel == RES_10) ? `ACL_RES10_MASK :
                           (res_sel == RES_16) ? `ACL_RES16_MASK :
                           (res_sel == RES_18) ? `ACL_RES18_MASK : `ACL_RES20_MASK;

    // Data slots are flagged valid only with a waiting sample, command slots only with a pending command
    wire [12:0] fill_valid;
    wire [15:0] tag_word;
    wire [12:3] wr_hot;
    wire [12:3] nxt_pend;
    assign fill_valid[0]    = |fill_valid[12:1];
    assign fill_valid[1]    = cmd_pend_ff;
    assign fill_valid[2]    = cmd_pend_ff & ~cmd_rd_ff;
    assign fill_valid[12:3] = pend_ff;
    // Tag: frame valid, slot valid bits 1..12, codec id
    assign tag_word[15]     = fill_valid[0];
    assign tag_word[1:0]    = `ACL_CODEC_ID;
    assign tag_word[2]      = 1'b0;          // Reserved, sent as zero
    genvar gi;
    generate
        for (gi = 1; gi <= 12; gi++) begin : g_slot
            assign tag_word[15-gi] = fill_valid[gi];
            if (gi >= 3) begin : g_data
                assign wr_hot[gi]   = tx_wr_valid & (tx_wr_slot == 4'(gi));
                // Set wins over the frame-start clear
                assign nxt_pend[gi] = wr_hot[gi] | (pend_ff[gi] & ~go);
            end
        end
    endgenerate
    wire [12:0] nxt_valid = go ? fill_valid : (stop ? 13'h0000 : valid_ff);

    wire [19:0] word_cmd  = {live_rd_ff, live_idx_ff, 12'h000};
    // Command data, zero for a read
    wire [19:0] word_cdat = live_rd_ff ? 20'h0_0000 : {live_dat_ff, 4'h0};
    wire [19:0] word_data = valid_ff[ns] ? (mem_rd_data & res_mask) : 20'h0_0000;
    wire [19:0] load_word = (ns == `ACL_TAG_SLOT)  ? {tag_word, 4'h0} :
                            (ns == `ACL_CMD_SLOT)  ? (valid_ff[1] ? word_cmd : 20'h0_0000) :
                            (ns == `ACL_CDAT_SLOT) ? (valid_ff[2] ? word_cdat : 20'h0_0000) :
                            word_data;
    // MSB first; the shifter moves on each rising bit clock
    wire [19:0] nxt_sh   = adv_cnt ? (last_bit ? load_word : {tx_sh_ff[18:0], 1'b0}) :
                           (stop ? 20'h0_0000 : tx_sh_ff);
    wire        nxt_sout = adv_cnt ? nxt_sh[19] : (stop ? 1'b0 : serial_out_line);
    // Sync high through the tag slot of each frame
    wire        nxt_sync = adv_cnt ? (nxt_slot == `ACL_TAG_SLOT) : (stop ? 1'b0 : frame_sync_line);

    // Next-slot word fetched on the falling edge before it is shifted
    wire mem_rd = running & bclk_fall & last_bit & (ns >= `ACL_FIRST_DATA);
    wire mem_wr = |wr_hot;

    // Stream store, written by the sample port
    aclink_slot_mem #(.WIDTH(20), .DEPTH(16), .AW(4)) u_mem (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .ce      (ce),
        .wr_en   (mem_wr),
        .wr_addr (tx_wr_slot),
        .wr_data (tx_wr_data),
        .rd_en   (mem_rd),
        .rd_addr (ns),
        .rd_data (mem_rd_data)
    );

    // Command port: one request held until the next frame takes it
    wire accept       = cmd_valid & cmd_ready;
    wire nxt_cmd_pend = accept | (cmd_pend_ff & ~go);
    wire take_cmd     = go & cmd_pend_ff;

    // Receive on falling bit clock, codec drives on rising
    wire        samp     = running & bclk_fall;
    wire        rx_done  = samp & last_bit;
    wire [19:0] rx_word  = {rx_sh_ff[18:0], sin_s2_ff};
    wire [3:0]  tbit     = `ACL_TAG_TOP - slot_ff;
    wire        tag_ok   = rx_tag_ff[15] & rx_tag_ff[tbit];
    wire        sts_a    = rx_done & tag_ok & (slot_ff == `ACL_CMD_SLOT);
    wire        sts_d    = rx_done & tag_ok & (slot_ff == `ACL_CDAT_SLOT);
    wire        data_hit = rx_done & tag_ok & (slot_ff >= `ACL_FIRST_DATA);
    wire [15:0] nxt_tag  = (rx_done & tag_now) ? rx_word[15:0] : rx_tag_ff;

    // Channel events
    wire [3:0] ev;
    assign ev[`ACL_EV_CMD] = take_cmd;
    assign ev[`ACL_EV_STS] = sts_d;
    assign ev[`ACL_EV_OVR] = |(wr_hot & pend_ff & ~{10{go}});
    assign ev[`ACL_EV_RX]  = data_hit;

    // Sticky channel events, set wins over clear
    wire [3:0] nxt_cs;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cs
            assign nxt_cs[gi] = ev[gi] | (channel_status_reg[gi] & ~cs_clear[gi]);
        end
    endgenerate
    // Separate enable and disable; disable wins
    wire [1:0] nxt_mask = (irq_mask_reg | irq_en_set) & ~irq_dis;
    // Global status per channel: codec, stream
    wire [1:0] nxt_status = {nxt_cs[3] | nxt_cs[2], nxt_cs[1] | nxt_cs[0]};
    // Pending and unmasked drives the line
    wire       nxt_irq = |(nxt_status & nxt_mask);

    // All state frozen while the peripheral clock is gated
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff        <= LINK_IDLE;
            slot_ff         <= `ACL_LAST_SLOT;
            sbit_ff         <= `ACL_DATA_LAST;
            tx_sh_ff        <= '0;
            serial_out_line <= 1'b0;
            frame_sync_line <= 1'b0;
            valid_ff        <= '0;
            pend_ff         <= '0;
            tx_req          <= 1'b0;
        end else if (ce) begin
            state_ff        <= nxt_state;
            slot_ff         <= nxt_slot;
            sbit_ff         <= nxt_sbit;
            tx_sh_ff        <= nxt_sh;
            serial_out_line <= nxt_sout;
            frame_sync_line <= nxt_sync;
            valid_ff        <= nxt_valid;
            pend_ff         <= nxt_pend;
            tx_req          <= go;
        end
    end

    // Command holding and live copies
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_pend_ff <= 1'b0;
            cmd_ready   <= 1'b1;
            cmd_rd_ff   <= 1'b0;
            cmd_idx_ff  <= '0;
            cmd_dat_ff  <= '0;
            live_rd_ff  <= 1'b0;
            live_idx_ff <= '0;
            live_dat_ff <= '0;
        end else if (ce) begin
            cmd_pend_ff <= nxt_cmd_pend;
            cmd_ready   <= ~nxt_cmd_pend;
            cmd_rd_ff   <= accept ? cmd_read : cmd_rd_ff;
            cmd_idx_ff  <= accept ? cmd_index : cmd_idx_ff;
            cmd_dat_ff  <= accept ? cmd_data : cmd_dat_ff;
            live_rd_ff  <= take_cmd ? cmd_rd_ff : live_rd_ff;
            live_idx_ff <= take_cmd ? cmd_idx_ff : live_idx_ff;
            live_dat_ff <= take_cmd ? cmd_dat_ff : live_dat_ff;
        end
    end

    // Receive path
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sh_ff  <= '0;
            rx_tag_ff <= '0;
            rx_valid  <= 1'b0;
            rx_slot   <= '0;
            rx_data   <= '0;
            sts_valid <= 1'b0;
            sts_index <= '0;
            sts_data  <= '0;
        end else if (ce) begin
            rx_sh_ff  <= samp ? rx_word : rx_sh_ff;
            rx_tag_ff <= nxt_tag;
            rx_valid  <= data_hit;
            rx_slot   <= data_hit ? slot_ff : rx_slot;
            rx_data   <= data_hit ? (rx_word & res_mask) : rx_data;
            sts_valid <= sts_d;
            sts_index <= sts_a ? rx_word[`ACL_IDX_HI:`ACL_IDX_LO] : sts_index;
            sts_data  <= sts_d ? rx_word[`ACL_DAT_HI:`ACL_DAT_LO] : sts_data;
        end
    end

    // Event and interrupt flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            channel_status_reg <= `ACL_CS_RST;
            irq_mask_reg       <= `ACL_MASK_RST;
            status_reg         <= '0;
            irq                <= 1'b0;
        end else if (ce) begin
            channel_status_reg <= nxt_cs;
            irq_mask_reg       <= nxt_mask;
            status_reg         <= nxt_status;
            irq                <= nxt_irq;
        end
    end

    // Checks on the link framing and the event logic
    a_sync_tag_slot: assert property (@(posedge mclk) disable iff (!rst_b)
        running && sbit_ff != `ACL_DATA_LAST |-> frame_sync_line == tag_now)
        else $error("frame sync not aligned to tag slot");
    a_out_on_rise: assert property (@(posedge mclk) disable iff (!rst_b)
        $changed(serial_out_line) |-> $past(bclk_rise) || $past(stop))
        else $error("serial out changed off a rising bit clock");
    a_read_zero_data: assert property (@(posedge mclk) disable iff (!rst_b)
        running && slot_ff == `ACL_CDAT_SLOT && live_rd_ff |-> !serial_out_line)
        else $error("read command data slot not zero");
    a_slot_bit_range: assert property (@(posedge mclk) disable iff (!rst_b)
        tag_now ? sbit_ff <= `ACL_TAG_LAST : sbit_ff <= `ACL_DATA_LAST)
        else $error("slot bit counter out of range");
    a_frame_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(frame_sync_line) |-> $past(slot_ff) == `ACL_LAST_SLOT && tx_req)
        else $error("frame sync rose outside frame wrap");
    a_rx_resolution: assert property (@(posedge mclk) disable iff (!rst_b)
        rx_valid && $stable(res_sel) |-> (rx_data & ~res_mask) == 20'h0_0000)
        else $error("received sample exceeds resolution");
    a_irq_line: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && ((|ev[1:0] && irq_mask_reg[0] && !irq_dis[0]) ||
               (|ev[3:2] && irq_mask_reg[1] && !irq_dis[1])) |=> irq)
        else $error("interrupt not raised for unmasked event");
    a_status_and: assert property (@(posedge mclk) disable iff (!rst_b)
        status_reg == {|channel_status_reg[3:2], |channel_status_reg[1:0]})
        else $error("global status disagrees with channel events");
    a_event_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && channel_status_reg[`ACL_EV_RX] && !cs_clear[`ACL_EV_RX] |=>
        channel_status_reg[`ACL_EV_RX])
        else $error("channel event lost without clear");
    a_mask_enable: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && irq_en_set[0] && !irq_dis[0] |=> irq_mask_reg[0])
        else $error("enable pulse did not set mask");
    a_gate_frozen: assert property (@(posedge mclk) disable iff (!rst_b)
        !ce |=> $stable(slot_ff) && $stable(serial_out_line) && $stable(irq))
        else $error("state moved while clock gated");
endmodule

//--- include/aclink_cfg.svh
// Purpose: AC-link controller constants
// Assumes: included by bare name
// Notes:   definitions only
`ifndef ACLINK_CFG_SVH
`define ACLINK_CFG_SVH

// Slot geometry
`define ACL_TAG_LAST    5'h0F
`define ACL_DATA_LAST   5'h13
`define ACL_TAG_SLOT    4'h0
`define ACL_CMD_SLOT    4'h1
`define ACL_CDAT_SLOT   4'h2
`define ACL_FIRST_DATA  4'h3
`define ACL_LAST_SLOT   4'hC
`define ACL_TAG_TOP     4'hF

// Field positions in command and status slots
`define ACL_RD_BIT      19
`define ACL_IDX_HI      18
`define ACL_IDX_LO      12
`define ACL_DAT_HI      19
`define ACL_DAT_LO      4

// Resolution masks, samples left-justified in the slot
`define ACL_RES10_MASK  20'hF_FC00
`define ACL_RES16_MASK  20'hF_FFF0
`define ACL_RES18_MASK  20'hF_FFFC
`define ACL_RES20_MASK  20'hF_FFFF

// Reset values and codec id
`define ACL_MASK_RST    2'h0
`define ACL_CS_RST      4'h0
`define ACL_CODEC_ID    2'h0

// Channel event bit positions
`define ACL_EV_CMD      0
`define ACL_EV_STS      1
`define ACL_EV_OVR      2
`define ACL_EV_RX       3

`endif

//--- include/aclink_pkg.sv
// Purpose: Types shared by the AC-link controller
// Assumes: nothing
// Notes:   enum codes left to the tool
package aclink_pkg;
    typedef enum logic [1:0] {RES_10, RES_16, RES_18, RES_20} res_e;
    typedef enum logic {LINK_IDLE, LINK_RUN} link_e;
endpackage

//--- hw/aclink_slot_mem.sv
// Purpose: Outgoing sample store, one word per slot
// Assumes: one write and one read port on mclk
// Notes:   read data comes out of a register
module aclink_slot_mem #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             mclk,    // System clock
    input  wire logic             rst_b,   // Async reset, active low
    input  wire logic             ce,      // Clock enable
    input  wire logic             wr_en,   // Write strobe
    input  wire logic [AW-1:0]    wr_addr, // Write slot
    input  wire logic [WIDTH-1:0] wr_data, // Write word
    input  wire logic             rd_en,   // Read strobe
    input  wire logic [AW-1:0]    rd_addr, // Read slot
    output logic      [WIDTH-1:0] rd_data  // Registered read word
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    // Array has no reset; unwritten slots are never flagged valid
    always_ff @(posedge mclk) begin
        if (ce && wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else if (ce && rd_en) begin
            rd_data <= mem_ff[rd_addr];
        end
    end
endmodule

//--- testbench/aclink_codec_model.sv
// Purpose: Behavioural codec at the far end of the link
// Assumes: bit clock runs free, frames start at the sync rise
// Notes:   only slots 0..3 carry bench data, later bits toggle
module aclink_codec_model (
    output logic        codec_bit_clock, // Bit clock to controller
    output logic        serial_in_line,  // Data to controller
    input  wire logic   serial_out_line, // Data from controller
    input  wire logic   frame_sync_line, // Frame sync from controller
    input  wire logic [75:0] in_frame,   // Tag and slots 1..3 to send
    output logic [75:0] out_frame,       // Tag and slots 1..3 seen
    output int          frame_cnt,       // Frames started
    output int          cap_cnt          // Frames captured
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [75:0] tx_sh;
    logic [75:0] rx_sh;
    int          bit_n;

    initial begin
        codec_bit_clock = 1'b0;
        serial_in_line  = 1'b0;
        out_frame       = '0;
        frame_cnt       = 0;
        cap_cnt         = 0;
        bit_n           = 256;
    end

    always #62.5 codec_bit_clock = ~codec_bit_clock;

    // frame latched at sync, first bit at once
    always @(posedge frame_sync_line) begin
        tx_sh          = in_frame;
        bit_n          = 0;
        serial_in_line = tx_sh[75];
        frame_cnt++;
    end

    // next bit MSB first; past slot 3 the line toggles
    always @(posedge codec_bit_clock) begin
        if (bit_n < 256)
            bit_n++;
        serial_in_line = (bit_n < 76) ? tx_sh[75-bit_n] : ~serial_in_line;
    end

    // Outgoing bits sampled mid-bit, well clear of the rise
    always @(negedge codec_bit_clock) begin
        if (bit_n < 76) begin
            rx_sh = {rx_sh[74:0], serial_out_line};
            if (bit_n == 75) begin
                out_frame = rx_sh;
                cap_cnt++;
            end
        end
    end
endmodule

//--- testbench/aclink_controller_tb.sv
// Purpose: Self-checking bench for the link controller
// Assumes: codec model answers every frame
// Notes:   results are noted in queues and checked by a monitor
`include "aclink_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module aclink_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aclink_pkg::*;
    logic mclk = 0, rst_b = 0, ce = 1, link_on = 0, bclk, sin, sout, fsync, tx_req;
    res_e res_sel = RES_20;
    logic tx_wr_valid = 0, cmd_valid = 0, cmd_read = 0, cmd_ready, rx_valid, sts_valid, irq;
    logic [3:0] tx_wr_slot = 4'h3, rx_slot, cs_clear = '0, channel_status_reg;
    logic [19:0] tx_wr_data = '0, rx_data, smp, rxw;
    logic [6:0] cmd_index = '0, sts_index, idx;
    logic [15:0] cmd_data = '0, sts_data, dat;
    logic [1:0] irq_en_set = '0, irq_dis = '0, irq_mask_reg, status_reg;
    logic [75:0] in_frame = '0, out_frame, ev, tv;
    int frame_cnt, cap_cnt, miscompares = 0, cmp_count = 0, fc;
    logic [23:0] rx_q[$];
    logic [22:0] sts_q[$];
    logic [75:0] tx_q[$];
    logic [19:0] masks[4] = '{`ACL_RES10_MASK, `ACL_RES16_MASK, `ACL_RES18_MASK, `ACL_RES20_MASK};

    always #4 mclk = ~mclk;

    aclink_controller aclink_controller_i (.mclk(mclk), .rst_b(rst_b), .ce(ce),
        .link_on(link_on), .codec_bit_clock(bclk), .serial_in_line(sin),
        .serial_out_line(sout), .frame_sync_line(fsync), .res_sel(res_sel),
        .tx_wr_valid(tx_wr_valid), .tx_wr_slot(tx_wr_slot), .tx_wr_data(tx_wr_data),
        .tx_req(tx_req), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_index(cmd_index),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rx_valid(rx_valid), .rx_slot(rx_slot),
        .rx_data(rx_data), .sts_valid(sts_valid), .sts_index(sts_index), .sts_data(sts_data),
        .irq_en_set(irq_en_set), .irq_dis(irq_dis), .cs_clear(cs_clear),
        .irq_mask_reg(irq_mask_reg), .status_reg(status_reg),
        .channel_status_reg(channel_status_reg), .irq(irq));
    aclink_codec_model aclink_codec_model_i (.codec_bit_clock(bclk), .serial_in_line(sin),
        .serial_out_line(sout), .frame_sync_line(fsync), .in_frame(in_frame),
        .out_frame(out_frame), .frame_cnt(frame_cnt), .cap_cnt(cap_cnt));

    task report_and_stop;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Bounded wait for the next frame start seen by the codec
    task wait_frame;
        int n;
        n = frame_cnt;
        for (int k = 0; k < 6000 && frame_cnt == n; k++)
            @(posedge mclk);
        if (frame_cnt == n) begin
            `CHK("frame start", 1'b1, 1'b0)
            report_and_stop();
        end
    endtask

    // One interrupt-group request, answer checked a cycle later
    task step(input [1:0] s, d, input [3:0] c, input [1:0] m, st, input i);
        @(posedge mclk);
        irq_en_set <= s;
        irq_dis    <= d;
        cs_clear   <= c;
        @(posedge mclk);
        {irq_en_set, irq_dis, cs_clear} <= '0;
        #1;
        `CHK("mask", m, irq_mask_reg)
        `CHK("status", st, status_reg)
        `CHK("irq", i, irq)
    endtask

    // Results popped oldest first; an unexpected one meets x and fails
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            ev = rx_q.size() ? 76'(rx_q.pop_front()) : 'x;
            `CHK("rx sample", ev[23:0], {rx_slot, rx_data})
        end
        if (sts_valid === 1'b1) begin
            ev = sts_q.size() ? 76'(sts_q.pop_front()) : 'x;
            `CHK("status word", ev[22:0], {sts_index, sts_data})
        end
    end
    always @(cap_cnt) begin
        if (tx_q.size()) begin
            tv = tx_q.pop_front();
            `CHK("frame head", tv, out_frame)
        end
    end

    initial begin
        void'($urandom(76));
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("ready at reset", 1'b1, cmd_ready)
        `CHK("sync at reset", 1'b0, fsync)
        @(posedge mclk);
        link_on <= 1'b1;
        wait_frame();
        // Each pass: command, doubled sample, codec slots, one resolution
        for (int i = 0; i < 4; i++) begin
            smp = $urandom;
            rxw = $urandom;
            idx = $urandom;
            dat = $urandom;
            repeat (2000) @(posedge mclk);
            res_sel     <= res_e'(i);
            cmd_valid   <= 1'b1;
            cmd_read    <= i[0];
            cmd_index   <= idx;
            cmd_data    <= dat;
            tx_wr_valid <= 1'b1;
            tx_wr_data  <= ~smp;
            @(posedge mclk);
            cmd_valid  <= 1'b0;
            tx_wr_data <= smp;
            @(posedge mclk);
            tx_wr_valid <= 1'b0;
            #1;
            `CHK("ready held low", 1'b0, cmd_ready)
            @(posedge mclk);
            #1;
            `CHK("overrun event", 1'b1, channel_status_reg[2])
            in_frame <= {16'hF000, 1'b0, idx, 12'h000, dat, 4'h0, rxw};
            sts_q.push_back({idx, dat});
            rx_q.push_back({4'h3, rxw & masks[i]});
            wait_frame();
            in_frame <= '0;
            tx_q.push_back({(i[0] ? 16'hD000 : 16'hF000), i[0], idx, 12'h000,
                            (i[0] ? 20'h0_0000 : {dat, 4'h0}), smp & masks[i]});
            wait_frame();
        end
        `CHK("all events", 4'hF, channel_status_reg)
        step(2'b10, 2'b00, 4'h0, 2'b10, 2'b11, 1'b1);
        step(2'b00, 2'b00, 4'hC, 2'b10, 2'b01, 1'b0);
        step(2'b01, 2'b01, 4'h0, 2'b10, 2'b01, 1'b0);
        step(2'b01, 2'b00, 4'h0, 2'b11, 2'b01, 1'b1);
        step(2'b00, 2'b11, 4'h3, 2'b00, 2'b00, 1'b0);
        // Gated clock: an enable pulse must not land
        @(posedge mclk);
        ce <= 1'b0;
        step(2'b01, 2'b00, 4'h0, 2'b00, 2'b00, 1'b0);
        @(posedge mclk);
        ce <= 1'b1;
        step(2'b01, 2'b00, 4'h0, 2'b01, 2'b00, 1'b0);
        // Unmasked command event raises the line in the frame that sends it
        @(posedge mclk);
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        wait_frame();
        `CHK("irq on command", 1'b1, irq)
        // Link stops at the frame end once link_on drops
        link_on <= 1'b0;
        fc = frame_cnt;
        repeat (4100) @(posedge mclk);
        `CHK("frames after stop", fc, frame_cnt)
        `CHK("left over", 0, rx_q.size() + sts_q.size() + tx_q.size())
        report_and_stop();
    end
endmodule
